// *** verilog/irq_share_pkg.sv ***
package irq_share_pkg;
	// control register bit positions
	localparam int CTL_TIMER_BIT   = 0;
	localparam int CTL_COUNTER_BIT = 1;
	localparam int CTL_EXT_BIT     = 2;
	localparam int CTL_REARM_BIT   = 7;
	// status register bit positions
	localparam int STS_TIMER_BIT   = 4;
	localparam int STS_COUNTER_BIT = 5;
	localparam int STS_EXT_BIT     = 6;
	// enable bits kept in the control register (bits 0..2)
	localparam int ENABLE_W        = 3;
	localparam logic [ENABLE_W-1:0] ENABLE_RESET = 3'h0;
	// register select index on address lines 15..12
	localparam logic [3:0] REG_INT_CONTROL = 4'hC;
	localparam logic [3:0] REG_INT_STATUS  = 4'hC;
	// fixed card pattern on address lines 9..1 (base 02E2)
	localparam logic [8:0] CARD_PATTERN    = 9'h171;
	// global re-arm window 02F3..02F7
	localparam logic [15:0] GLOBAL_REARM_LO = 16'h02F3;
	localparam logic [15:0] GLOBAL_REARM_HI = 16'h02F7;
	// pulse length in system clock cycles
	localparam int PULSE_CYCLES    = 2;
	localparam logic [1:0] PULSE_LAST = 2'(PULSE_CYCLES - 1);
	typedef enum logic [1:0] {
		ST_ARMED   = 2'b00,
		ST_PULSE   = 2'b01,
		ST_BLOCKED = 2'b10
	} arm_state_t;
endpackage : irq_share_pkg

// *** verilog/sync3.sv ***
`timescale 1ns/100ps
module sync3 (
	// clock and reset
	input  wire logic ref_clk_in,
	input  wire logic nrst_in,
	// level
	input  wire logic async_in,
	output logic      level_out
);
	typedef struct packed {
		logic [2:0] sh;
		logic       lvl;
	} sync_t;
	sync_t r;
	sync_t next_r;
	always_comb begin
		next_r = r;
		next_r.sh = {r.sh[1:0], async_in};
		// accept a change only when stages two and three agree
		if (r.sh[2] == r.sh[1]) begin
			next_r.lvl = r.sh[2];
		end
	end
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign level_out = r.lvl;
endmodule // sync3

// *** verilog/shared_irq.sv ***
`timescale 1ns/100ps
// Behaviour
// - four sources, each masked by software before raising interrupts
// - control bit 0 enables the cascaded timer source
// - control bit 1 enables the 16-bit counter source
// - control bit 2 enables external request together with end of conversion
// - control bit 3 reserved, bits 4-6 unused; no function
// - writing one to control bit 7 re-arms this card
// - board reset clears the whole control register
// - status bits 0-2 echo enables, bit 3 zero; bit 7 reads zero
// - status bit 4 is the live second timer stage level
// - status bit 5 is the live counter output level
// - status bit 6 is external request OR end of conversion
// - sources ANDed with enables, ORed into one trigger
// - trigger drives the request line low for two clocks
// - driver floats outside the pulse so cards share the line
// - any low on the shared line blocks further pulses until re-armed
// - re-arm on local bit OR global clear
// - local re-arm honoured only when card select bits match
// - write to level address 02F3..02F7 re-arms globally; data ignored
// - output level chosen by board switch, IRQ3 to IRQ7
// - timer source is the second cascaded stage output
// - board reset is the inverse of the host reset drive
module shared_irq
	import irq_share_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	// host i/o bus
	input  wire logic [15:0] io_addr_in,
	input  wire logic [7:0]  io_wdata_in,
	input  wire logic        io_wr_in,
	input  wire logic        io_rd_in,
	output logic      [7:0]  io_rdata_out,
	output logic             io_rdata_oe_out,
	// board straps
	input  wire logic [1:0]  card_number_in,
	input  wire logic [2:0]  level_select_switch_in,
	// interrupt sources
	input  wire logic        timer_stage2_in,
	input  wire logic        counter_out_in,
	input  wire logic        ext_req_n_in,
	input  wire logic        adc_eoc_in,
	// shared request lines, IRQ3..IRQ7
	input  wire logic [4:0]  irq_line_in,
	output logic      [4:0]  irq_line_out,
	output logic      [4:0]  irq_line_oe_out
);
	typedef struct packed {
		logic [ENABLE_W-1:0] enable;
		arm_state_t          state;
		logic [1:0]          pulse_cnt;
		logic [2:0]          level_sel;
		logic                level_taken;
		logic                line_prev;
		logic [7:0]          rdata;
		logic                rd_oe;
	} state_t;

	state_t r;
	state_t next_r;

	// filtered source levels, all active high
	logic        timer_src_level;
	logic        counter_src_level;
	logic        ext_req_sync;
	logic        eoc_sync;
	logic        ext_src_level;
	logic [2:0]  src_masked;
	logic        trigger;
	// host bus decode
	logic        card_hit;
	logic        ctl_wr;
	logic        sts_rd;
	logic        local_rearm;
	logic        global_rearm;
	logic        rearm;
	logic [15:0] level_rearm_addr;
	logic [7:0]  status_byte;
	// shared lines after the filter, high while a line is held low
	logic [4:0]  line_low_sync;
	logic [4:0]  level_mask;
	logic        line_low;
	logic        line_fell;

	// external pins pass the three-stage filter
	sync3 u_sync_timer (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (timer_stage2_in),
		.level_out  (timer_src_level)
	);
	sync3 u_sync_counter (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (counter_out_in),
		.level_out  (counter_src_level)
	);
	// request pin idles high; inverted ahead of the filter so the cleared
	// filter reads as idle and no false request shows right after reset
	sync3 u_sync_ext (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (~ext_req_n_in),
		.level_out  (ext_req_sync)
	);
	sync3 u_sync_eoc (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (adc_eoc_in),
		.level_out  (eoc_sync)
	);

	// shared lines idle high; inverted for the same reason, otherwise the
	// filter leaving reset would look like a falling line and block the card
	sync3 u_sync_irq3 (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (~irq_line_in[0]),
		.level_out  (line_low_sync[0])
	);
	sync3 u_sync_irq4 (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (~irq_line_in[1]),
		.level_out  (line_low_sync[1])
	);
	sync3 u_sync_irq5 (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (~irq_line_in[2]),
		.level_out  (line_low_sync[2])
	);
	sync3 u_sync_irq6 (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (~irq_line_in[3]),
		.level_out  (line_low_sync[3])
	);
	sync3 u_sync_irq7 (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   (~irq_line_in[4]),
		.level_out  (line_low_sync[4])
	);

	assign ext_src_level = ext_req_sync | eoc_sync;

	// card select: fixed pattern on the low lines, adapter number above it
	always_comb begin
		card_hit = 1'b0;
		if (io_addr_in[9:1] == CARD_PATTERN && io_addr_in[11:10] == card_number_in) begin
			card_hit = 1'b1;
		end
	end

	// register select; control and status share one word, split by direction
	always_comb begin
		ctl_wr = 1'b0;
		sts_rd = 1'b0;
		if (card_hit && io_addr_in[15:12] == REG_INT_CONTROL && io_wr_in) begin
			ctl_wr = 1'b1;
		end else if (card_hit && io_addr_in[15:12] == REG_INT_STATUS && io_rd_in) begin
			sts_rd = 1'b1;
		end
	end

	assign local_rearm  = ctl_wr & io_wdata_in[CTL_REARM_BIT];
	// each level owns one address of the window, lowest level at the bottom
	assign level_rearm_addr = GLOBAL_REARM_LO + 16'(r.level_sel);
	// data value is irrelevant for the global clear; no card select applies
	assign global_rearm = io_wr_in
		&& r.level_taken
		&& io_addr_in >= GLOBAL_REARM_LO
		&& io_addr_in <= GLOBAL_REARM_HI
		&& io_addr_in == level_rearm_addr;
	assign rearm = local_rearm | global_rearm;

	// each enable gates its own source; any mix may be enabled at once
	assign src_masked[CTL_TIMER_BIT] = r.enable[CTL_TIMER_BIT]
		& timer_src_level;
	assign src_masked[CTL_COUNTER_BIT] = r.enable[CTL_COUNTER_BIT]
		& counter_src_level;
	assign src_masked[CTL_EXT_BIT] = r.enable[CTL_EXT_BIT]
		& ext_src_level;
	assign trigger = |src_masked;

	always_comb begin
		status_byte = 8'h00;
		status_byte[ENABLE_W-1:0] = r.enable;
		status_byte[STS_TIMER_BIT] = timer_src_level;
		status_byte[STS_COUNTER_BIT] = counter_src_level;
		status_byte[STS_EXT_BIT] = ext_src_level;
	end

	// one-hot level from the captured switch code, lowest level in bit 0
	always_comb begin
		if (r.level_sel == 3'h0) begin
			level_mask = 5'h01;
		end else if (r.level_sel == 3'h1) begin
			level_mask = 5'h02;
		end else if (r.level_sel == 3'h2) begin
			level_mask = 5'h04;
		end else if (r.level_sel == 3'h3) begin
			level_mask = 5'h08;
		end else begin
			level_mask = 5'h10;
		end
	end

	// only the selected level is watched, and only once the switch is taken
	assign line_low = |(line_low_sync & level_mask) & r.level_taken;
	assign line_fell = line_low & ~r.line_prev;

	always_comb begin
		next_r = r;
		// switch is sampled once after reset release; must be set before install
		if (!r.level_taken) begin
			if (level_select_switch_in > 3'h4) begin
				next_r.level_sel = 3'h4;
			end else begin
				next_r.level_sel = level_select_switch_in;
			end
			next_r.level_taken = 1'b1;
		end
		if (ctl_wr) begin
			// bits 3..6 have no storage
			next_r.enable = io_wdata_in[ENABLE_W-1:0];
		end
		next_r.rd_oe = sts_rd;
		if (sts_rd) begin
			next_r.rdata = status_byte;
		end
		next_r.line_prev = line_low;
		case (r.state)
			ST_ARMED: begin
				if (line_fell) begin
					next_r.state = ST_BLOCKED;
				end else if (trigger && r.level_taken) begin
					next_r.state = ST_PULSE;
					next_r.pulse_cnt = 2'h0;
				end
			end
			ST_PULSE: begin
				if (r.pulse_cnt == PULSE_LAST) begin
					// own pulse also blocks, as any low on the line does
					next_r.state = ST_BLOCKED;
				end else begin
					next_r.pulse_cnt = r.pulse_cnt + 2'h1;
				end
			end
			ST_BLOCKED: begin
				// a fresh low on the line in the re-arm cycle keeps the block
				if (rearm && !line_fell) begin
					next_r.state = ST_ARMED;
				end
			end
			default: begin
				next_r.state = ST_BLOCKED;
			end
		endcase
	end

	// nrst_in is the board reset, already the inverse of host reset drive
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r.enable <= ENABLE_RESET;
			r.state <= ST_ARMED;
			r.pulse_cnt <= '0;
			r.level_sel <= '0;
			r.level_taken <= 1'b0;
			r.line_prev <= 1'b0;
			r.rdata <= '0;
			r.rd_oe <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		irq_line_out = 5'h00;
		irq_line_oe_out = 5'h00;
		if (r.state == ST_PULSE) begin
			// drive low only; the enable drops and the line floats otherwise
			irq_line_oe_out = level_mask;
		end
	end

	assign io_rdata_out = r.rdata;
	assign io_rdata_oe_out = r.rd_oe;
endmodule // shared_irq

// *** testbench/shared_irq_assertions.sv ***
`timescale 1ns/100ps
module shared_irq_checker
	import irq_share_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        nrst_in,
	input wire logic [15:0] io_addr_in,
	input wire logic        io_rd_in,
	input wire logic [7:0]  io_rdata_out,
	input wire logic        io_rdata_oe_out,
	input wire logic [1:0]  card_number_in,
	input wire logic [2:0]  level_select_switch_in,
	input wire logic        timer_stage2_in,
	input wire logic        counter_out_in,
	input wire logic        ext_req_n_in,
	input wire logic        adc_eoc_in,
	input wire logic [4:0]  irq_line_out,
	input wire logic [4:0]  irq_line_oe_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	logic       hit;
	logic       src;
	logic       drv;
	logic [2:0] sel;
	assign hit = io_addr_in[15:1] == {REG_INT_STATUS, card_number_in, CARD_PATTERN};
	assign src = timer_stage2_in | counter_out_in | !ext_req_n_in | adc_eoc_in;
	assign drv = |irq_line_oe_out;
	assign sel = (level_select_switch_in > 3'h4) ? 3'h4 : level_select_switch_in;
	a_pulse_two_cyc: assert property ($rose(drv) |=> drv ##1 !drv)
		else $error("pulse length wrong");
	a_drive_low_only: assert property (irq_line_out == 5'h00)
		else $error("line driven high");
	a_level_routed: assert property (drv |-> irq_line_oe_out == 5'h01 << sel)
		else $error("wrong level driven");
	a_read_answer: assert property (io_rd_in && hit |=> io_rdata_oe_out)
		else $error("status read not answered");
	a_read_quiet: assert property (!(io_rd_in && hit) |=> !io_rdata_oe_out)
		else $error("read data without read");
	a_status_zero_bits: assert property (io_rdata_oe_out |-> !io_rdata_out[7] && !io_rdata_out[3])
		else $error("status bit 3 or 7 set");
	a_idle_no_pulse: assert property (!src [*6] |=> !$rose(drv))
		else $error("pulse with no source");
	a_reset_quiet: assert property ($rose(nrst_in) |-> !drv [*4])
		else $error("pulse right after reset");
	cover property ($rose(drv));
	cover property (io_rd_in && hit);
	cover property ($fell(drv) ##[1:40] $rose(drv));
endmodule // shared_irq_checker

bind shared_irq shared_irq_checker chk_u (
	.ref_clk_in             (ref_clk_in),
	.nrst_in                (nrst_in),
	.io_addr_in             (io_addr_in),
	.io_rd_in               (io_rd_in),
	.io_rdata_out           (io_rdata_out),
	.io_rdata_oe_out        (io_rdata_oe_out),
	.card_number_in         (card_number_in),
	.level_select_switch_in (level_select_switch_in),
	.timer_stage2_in        (timer_stage2_in),
	.counter_out_in         (counter_out_in),
	.ext_req_n_in           (ext_req_n_in),
	.adc_eoc_in             (adc_eoc_in),
	.irq_line_out           (irq_line_out),
	.irq_line_oe_out        (irq_line_oe_out)
);

// *** testbench/host_irq_model.sv ***
`timescale 1ns/100ps
module host_irq_model (
	// card drivers and other cards
	input  wire logic [4:0] drive_oe_in,
	input  wire logic [4:0] drive_val_in,
	input  wire logic [4:0] other_pull_in,
	// resolved levels
	output logic      [4:0] line_out
);
	// pulled up; any driver pulling low wins
	always_comb
		for (int i = 0; i < 5; i++)
			line_out[i] = ((drive_oe_in[i] && !drive_val_in[i]) || other_pull_in[i]) ? 1'b0 : 1'b1;
endmodule // host_irq_model

// *** testbench/shared_irq_tb_top.sv ***
`timescale 1ns/100ps
module shared_irq_tb_top;
	import irq_share_pkg::*;
	localparam logic [15:0] CTL = 16'hC6E2, OTHER = 16'hC2E2, GLOB = 16'h02F7, GLOB3 = 16'h02F3;
	logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rdata_oe;
	logic        tmr = 1'b0, cnt = 1'b0, ext_n = 1'b1, eoc = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [2:0]  sw = 3'h4;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [4:0]  line, lout, loe, pull = 5'h00;
	int          failures = 0, n_tests = 0, np = 0, np0 = 0;
	always #10 clk = ~clk;
	// counted away from the launching edge, where the enable has settled
	always @(negedge clk) begin
		if (loe[4]) np++;
		if (loe[0]) np0++;
	end
	host_irq_model host_u (.drive_oe_in(loe), .drive_val_in(lout), .other_pull_in(pull),
		.line_out(line));
	shared_irq dut_u (.ref_clk_in(clk), .nrst_in(nrst), .io_addr_in(addr), .io_wdata_in(wdata),
		.io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdata), .io_rdata_oe_out(rdata_oe),
		.card_number_in(2'h1), .level_select_switch_in(sw), .timer_stage2_in(tmr),
		.counter_out_in(cnt), .ext_req_n_in(ext_n), .adc_eoc_in(eoc), .irq_line_in(line),
		.irq_line_out(lout), .irq_line_oe_out(loe));
	task check(string what, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task end_of_test;
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task wr_reg(logic [15:0] a, logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// 8'hff never expected, so a missing answer shows
	task rd_reg(logic [7:0] exp);
		@(negedge clk);
		addr = CTL;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		check("status", rdata_oe === 1'b1 ? rdata : 8'hFF, exp);
	endtask
	task pulses(logic [7:0] exp);
		cyc(8);
		check("pulses", 8'(np), exp);
	endtask
	task t_timer;
		wr_reg(CTL, 8'h7F);
		rd_reg(8'h07);
		tmr = 1'b1;
		pulses(8'd2);
		rd_reg(8'h17);
		pulses(8'd2);
		wr_reg(CTL, 8'h87);
		pulses(8'd4);
		wr_reg(OTHER, 8'h87);
		pulses(8'd4);
		wr_reg(GLOB, 8'h5A);
		pulses(8'd6);
	endtask
	task t_mask;
		wr_reg(CTL, 8'h86);
		pulses(8'd6);
		cnt = 1'b1;
		pulses(8'd8);
		rd_reg(8'h36);
		cnt = 1'b0;
		tmr = 1'b0;
		ext_n = 1'b0;
		wr_reg(CTL, 8'h84);
		pulses(8'd10);
		rd_reg(8'h44);
		ext_n = 1'b1;
		eoc = 1'b1;
		wr_reg(CTL, 8'h84);
		pulses(8'd12);
		rd_reg(8'h44);
		eoc = 1'b0;
	endtask
	// another card's pulse must block this one too
	task t_other;
		wr_reg(CTL, 8'h81);
		cyc(4);
		pull[4] = 1'b1;
		cyc(3);
		pull[4] = 1'b0;
		tmr = 1'b1;
		pulses(8'd12);
		wr_reg(GLOB, 8'h00);
		pulses(8'd14);
	endtask
	// second reset with the switch on the lowest level; only its own address re-arms
	task t_level;
		tmr = 1'b0;
		sw = 3'h0;
		nrst = 1'b0;
		cyc(2);
		nrst = 1'b1;
		cyc(2);
		rd_reg(8'h00);
		wr_reg(CTL, 8'h01);
		tmr = 1'b1;
		cyc(8);
		check("lowest level pulses", 8'(np0), 8'd2);
		check("top level pulses", 8'(np), 8'd14);
		wr_reg(GLOB, 8'h00);
		cyc(8);
		check("other level re-arm", 8'(np0), 8'd2);
		wr_reg(GLOB3, 8'h00);
		cyc(8);
		check("own level re-arm", 8'(np0), 8'd4);
	endtask
	initial begin
		cyc(12);
		nrst = 1'b1;
		cyc(2);
		rd_reg(8'h00);
		t_timer;
		t_mask;
		t_other;
		t_level;
		end_of_test;
	end
	initial begin
		#200000;
		failures++;
		end_of_test;
	end
endmodule // shared_irq_tb_top
